/* File: core/bpr_regs.sv */
`timescale 1ns/100ps
`default_nettype none
module bpr_regs
  import bpr_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Serial link from the host, sda open drain
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Comparator, watchdog and pin levels from the analog side
  input wire bpr_sense_t sense_i,
  // Alert and block controls
  output logic system_alert_n_o,
  output bpr_pins_t pins_o
);

  bpr_state_t q;
  bpr_state_t n;

  logic scl_now;
  logic sda_now;
  logic scl_rise;
  logic scl_fall;
  logic link_start;
  logic link_stop;
  bpr_out_ctl_t out_ctl;
  bpr_power_state_control_t power_state_control;
  bpr_func_ctl_t func_ctl;
  bpr_cell_ctl_t cell_ctl;
  bpr_sense_t sense_s;
  bpr_status_t status;
  logic sleeping;
  logic [2:0] ptr_idx;
  logic ptr_is_ctl;
  logic [7:0] rd_byte;
  logic [3:0] fault_now;
  logic [BPR_CTL_COUNT-1:0][7:0] wr_val;
  logic hold_off;
  logic mon_on;
  bpr_pins_t pins_nxt;

  assign scl_now = q.sync2[BPR_LANE_SCL];
  assign sda_now = q.sync2[BPR_LANE_SDA];
  assign scl_rise = scl_now & ~q.scl_d;
  assign scl_fall = ~scl_now & q.scl_d;
  // Start and stop are only seen while the clock stays high on both samples.
  assign link_start = scl_now & q.scl_d & q.sda_d & ~sda_now;
  assign link_stop = scl_now & q.scl_d & ~q.sda_d & sda_now;

  assign sense_s = bpr_sense_t'(q.sync2[BPR_SYNC_W-3:0]);
  assign out_ctl = bpr_out_ctl_t'(q.ctl[BPR_IDX_OUTPUT]);
  assign power_state_control = bpr_power_state_control_t'(q.ctl[BPR_IDX_STATE]);
  assign func_ctl = bpr_func_ctl_t'(q.ctl[BPR_IDX_FUNC]);
  assign cell_ctl = bpr_cell_ctl_t'(q.ctl[BPR_IDX_CELL]);

  // The sleep pin and the sleep request bit both put the device to sleep.
  assign sleeping = sense_s.sleep_pin | power_state_control.sleep_request;

  // Sleep disables all current and watchdog faults.
  always_comb begin
    status = '0;
    status.short_discharge_flag = sense_s.short_discharge & ~func_ctl.short_discharge_sense_off
                                  & ~sleeping;
    status.short_charge_flag = sense_s.short_charge & ~func_ctl.short_charge_sense_off
                               & ~sleeping;
    status.overload_flag = sense_s.overload & ~func_ctl.overload_sense_off & ~sleeping;
    status.watchdog_fault_flag = sense_s.watchdog_timeout & ~power_state_control.clock_monitor_disable
                                 & ~sleeping;
    status.sleeping_flag = sleeping;
    status.zero_volt_clamp_flag = sense_s.zero_volt_clamp;
  end

  assign fault_now = {status.watchdog_fault_flag, status.overload_flag,
                      status.short_charge_flag, status.short_discharge_flag};

  assign ptr_idx = 3'(q.ptr - BPR_ADDR_FIRST_CTL);
  assign ptr_is_ctl = (q.ptr >= BPR_ADDR_FIRST_CTL) && (q.ptr <= BPR_ADDR_LAST);

  // An unmapped pointer is still acknowledged and reads as zero.
  always_comb begin
    if (sleeping) begin
      rd_byte = BPR_NO_DATA;
    end else if (q.ptr == BPR_ADDR_STATUS) begin
      rd_byte = status;
    end else if (ptr_is_ctl) begin
      rd_byte = q.ctl[ptr_idx];
    end else begin
      rd_byte = BPR_ZERO_BYTE;
    end
  end

  always_comb begin
    logic load_rd;
    logic status_rd;
    logic wr_en;
    logic release_evt;
    load_rd = 1'b0;
    status_rd = 1'b0;
    wr_en = 1'b0;
    release_evt = 1'b0;
    n = q;

    n.sync1 = {scl_i, sda_i, sense_i};
    n.sync2 = q.sync1;
    n.scl_d = scl_now;
    n.sda_d = sda_now;

    case (q.st)
      BPR_ST_IDLE: begin
        n.sda_drive = 1'b0;
      end
      BPR_ST_ADDR, BPR_ST_REG, BPR_ST_WDATA: begin
        if (scl_rise && q.bit_cnt != BPR_BYTE_BITS) begin
          n.shift = {q.shift[BPR_MSB-1:0], sda_now};
          n.bit_cnt = q.bit_cnt + BPR_FIRST_BIT;
        end else if (scl_fall && q.bit_cnt == BPR_BYTE_BITS) begin
          n.bit_cnt = '0;
          n.st = BPR_ST_ACK;
          n.sda_drive = 1'b1;
          if (q.st == BPR_ST_ADDR) begin
            // Any other address, the general call among them, gets no answer.
            if (q.shift[BPR_MSB:1] != BPR_SLAVE_ADDR) begin
              n.st = BPR_ST_IDLE;
              n.sda_drive = 1'b0;
            end else if (q.shift[0]) begin
              n.ack_next = BPR_ST_RDATA;
            end else begin
              n.ack_next = BPR_ST_REG;
            end
          end else if (q.st == BPR_ST_REG) begin
            n.ptr = q.shift;
            n.ack_next = BPR_ST_WDATA;
          end else begin
            // Further data bytes land on the same register.
            wr_en = ptr_is_ctl;
            n.ack_next = BPR_ST_WDATA;
          end
        end
      end
      BPR_ST_ACK: begin
        if (scl_fall) begin
          n.sda_drive = 1'b0;
          if (q.ack_next == BPR_ST_RDATA) begin
            load_rd = 1'b1;
          end else begin
            n.st = q.ack_next;
          end
        end
      end
      BPR_ST_RDATA: begin
        if (scl_fall) begin
          if (q.bit_cnt == BPR_BYTE_BITS) begin
            n.sda_drive = 1'b0;
            n.st = BPR_ST_RACK;
          end else begin
            n.shift = {q.shift[BPR_MSB-1:0], 1'b0};
            n.sda_drive = ~q.shift[BPR_MSB-1];
            n.bit_cnt = q.bit_cnt + BPR_FIRST_BIT;
          end
        end
      end
      BPR_ST_RACK: begin
        if (scl_rise) begin
          n.master_ack = ~sda_now;
        end else if (scl_fall) begin
          if (q.master_ack) begin
            load_rd = 1'b1;
          end else begin
            n.st = BPR_ST_IDLE;
          end
        end
      end
      default: begin
        n.st = BPR_ST_IDLE;
        n.sda_drive = 1'b0;
      end
    endcase

    if (load_rd) begin
      n.shift = rd_byte;
      n.sda_drive = ~rd_byte[BPR_MSB];
      n.bit_cnt = BPR_FIRST_BIT;
      n.st = BPR_ST_RDATA;
      // A read in sleep returns nothing, so it does not count as seen.
      status_rd = (q.ptr == BPR_ADDR_STATUS) & ~sleeping;
    end

    if (link_start) begin
      n.st = BPR_ST_ADDR;
      n.bit_cnt = '0;
      n.sda_drive = 1'b0;
    end else if (link_stop) begin
      n.st = BPR_ST_IDLE;
      n.sda_drive = 1'b0;
    end

    // Writes are taken in sleep too, and reserved bits never store.
    if (wr_en) begin
      n.ctl[ptr_idx] = wr_val[ptr_idx];
    end

    // The strap settles through the synchroniser before it is caught.
    if (!q.strap_done) begin
      n.strap_cnt = q.strap_cnt + 2'h1;
      if (q.strap_cnt == BPR_STRAP_LOAD) begin
        n.strap_done = 1'b1;
        n.ctl[BPR_IDX_OUTPUT][$bits(out_ctl.fault_latch_release)+
                              $bits(out_ctl.discharge_fet_on)] =
          sense_s.precharge_mode_strap;
      end
    end

    // Only the falling half of a 0-1-0 toggle frees the latch; a fault still present wins.
    release_evt = q.release_prev & ~out_ctl.fault_latch_release;
    n.release_prev = out_ctl.fault_latch_release;
    n.fault_latched = (|fault_now) | (q.fault_latched & ~release_evt);

    n.fault_prev = fault_now;
    n.alert = (|(fault_now & ~q.fault_prev)) | (q.alert & ~status_rd);

    n.pins = pins_nxt;
  end

  // Each slot keeps only its writable bits, so reserved bits read back as zero.
  for (genvar s = 0; s < BPR_CTL_COUNT; s++) begin : g_slot
    assign wr_val[s] = q.shift & BPR_WR_MASK[s];
  end

  assign hold_off = q.fault_latched | sleeping;
  assign mon_on = func_ctl.voltage_monitor_enable & ~sleeping;

  // Sleep and a latched fault override the host's bits but never the stored
  // bytes, so every output comes back as it was once sleep ends.
  always_comb begin
    pins_nxt = '0;

    // Power path drives.
    pins_nxt.discharge_fet_on =
      out_ctl.discharge_fet_on
      & ~hold_off;
    pins_nxt.charge_fet_on =
      out_ctl.charge_fet_on
      & ~hold_off;
    pins_nxt.zero_volt_charge_fet =
      ~out_ctl.zero_volt_fet_off_n
      & ~hold_off;
    pins_nxt.open_drain_enable =
      out_ctl.open_drain_enable
      & ~sleeping;
    pins_nxt.fault_latched =
      q.fault_latched;

    // Power modes and supervision.
    pins_nxt.ship_mode =
      power_state_control.ship_request
      & sense_s.pack_absent;
    pins_nxt.clock_monitor_disable =
      power_state_control.clock_monitor_disable;

    // Voltage monitor path.
    pins_nxt.voltage_monitor_enable =
      mon_on;
    pins_nxt.cell_out_ground =
      ~mon_on;
    pins_nxt.pack_translate_enable =
      func_ctl.pack_translate_enable
      & mon_on;
    pins_nxt.thermistor_power_on =
      func_ctl.thermistor_power_on
      & ~sleeping;

    // Current sensing is switched off while asleep.
    pins_nxt.overload_sense_off =
      func_ctl.overload_sense_off
      | sleeping;
    pins_nxt.short_charge_sense_off =
      func_ctl.short_charge_sense_off
      | sleeping;
    pins_nxt.short_discharge_sense_off =
      func_ctl.short_discharge_sense_off
      | sleeping;

    // Cell selection and balancing.
    pins_nxt.cell_pick =
      cell_ctl.cell_pick;
    pins_nxt.monitor_mode =
      cell_ctl.monitor_mode;
    pins_nxt.balance_en =
      sleeping ? 4'h0 : cell_ctl.balance_en;

    // Threshold and delay codes pass straight to the analog side.
    pins_nxt.overload_threshold =
      q.ctl[BPR_IDX_OLV];
    pins_nxt.overload_delay =
      q.ctl[BPR_IDX_OLT];
    pins_nxt.short_charge_config =
      q.ctl[BPR_IDX_SCC];
    pins_nxt.short_discharge_config =
      q.ctl[BPR_IDX_SCD];
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_o = q.sda_drive;
  assign system_alert_n_o = ~q.alert;
  assign pins_o = q.pins;

endmodule
`default_nettype wire

/* File: include/bpr_pkg.sv */
// Summary of operation
// - Nine byte registers, 0x00 status read-only.
// - Reading status deasserts the system alert.
// - Status b0/b1 show short-circuit, discharge/charge.
// - Status b2 shows current strictly above overload.
// - Status b3 shows watchdog clock fault timeout.
// - Status b4 sleeping, b5 zero-volt clamp.
// - Release bit toggled 0-1-0 frees fault latch.
// - Output b1 drives discharge FET on.
// - Output b2 charge FET, reset from strap.
// - Output b3 high turns zero-volt FET off.
// - Output b4 pulls open-drain output low.
// - State b0 requests sleep mode.
// - State b1 enters ship when pack removed.
// - State b2 disables watchdog clock monitoring.
// - Function b0 enables monitoring, else cell grounded.
// - Function b1 presents pack voltage, overrides cell.
// - Function b2-b4 disable overload/short sensing.
// - Function b5 powers the thermistor.
// - Cell b1:b0 picks cell, bottom to top.
// - Cell b3:b2 selects monitor mode.
// - Cell b4-b7 enable balance paths, bottom first.
// - Slave only at 7-bit address 0x20.
// - Register pointer never auto-increments.
// - Sleep accepts writes, returns no read data.
package bpr_pkg;

  localparam logic [6:0] BPR_SLAVE_ADDR = 7'h20;
  localparam logic [7:0] BPR_ADDR_STATUS = 8'h00;
  localparam logic [7:0] BPR_ADDR_FIRST_CTL = 8'h01;
  localparam logic [7:0] BPR_ADDR_LAST = 8'h08;
  localparam int BPR_CTL_COUNT = 8;

  // Control register slots, slot = address - 1.
  localparam logic [2:0] BPR_IDX_OUTPUT = 3'h0;
  localparam logic [2:0] BPR_IDX_STATE = 3'h1;
  localparam logic [2:0] BPR_IDX_FUNC = 3'h2;
  localparam logic [2:0] BPR_IDX_CELL = 3'h3;
  localparam logic [2:0] BPR_IDX_OLV = 3'h4;
  localparam logic [2:0] BPR_IDX_OLT = 3'h5;
  localparam logic [2:0] BPR_IDX_SCC = 3'h6;
  localparam logic [2:0] BPR_IDX_SCD = 3'h7;

  // Writable bits per slot, slot 7 first.
  localparam logic [7:0][7:0] BPR_WR_MASK = {8'hFF, 8'hFF, 8'h0F, 8'h1F,
                                             8'hFF, 8'h3F, 8'h07, 8'h1F};

  localparam logic [7:0] BPR_NO_DATA = 8'hFF;
  localparam logic [7:0] BPR_ZERO_BYTE = 8'h00;
  localparam logic [3:0] BPR_BYTE_BITS = 4'h8;
  localparam logic [3:0] BPR_FIRST_BIT = 4'h1;
  localparam int BPR_MSB = 7;
  localparam logic [1:0] BPR_STRAP_LOAD = 2'h2;

  // Synchroniser lanes: the two link pins above the sense inputs.
  localparam int BPR_SYNC_W = 10;
  localparam int BPR_LANE_SCL = 9;
  localparam int BPR_LANE_SDA = 8;

  typedef struct packed {
    logic short_discharge;
    logic short_charge;
    logic overload;
    logic watchdog_timeout;
    logic zero_volt_clamp;
    logic sleep_pin;
    logic pack_absent;
    logic precharge_mode_strap;
  } bpr_sense_t;

  typedef struct packed {
    logic [1:0] pad;
    logic zero_volt_clamp_flag;
    logic sleeping_flag;
    logic watchdog_fault_flag;
    logic overload_flag;
    logic short_charge_flag;
    logic short_discharge_flag;
  } bpr_status_t;

  typedef struct packed {
    logic [2:0] pad;
    logic open_drain_enable;
    logic zero_volt_fet_off_n;
    logic charge_fet_on;
    logic discharge_fet_on;
    logic fault_latch_release;
  } bpr_out_ctl_t;

  typedef struct packed {
    logic [4:0] pad;
    logic clock_monitor_disable;
    logic ship_request;
    logic sleep_request;
  } bpr_power_state_control_t;

  typedef struct packed {
    logic [1:0] pad;
    logic thermistor_power_on;
    logic short_discharge_sense_off;
    logic short_charge_sense_off;
    logic overload_sense_off;
    logic pack_translate_enable;
    logic voltage_monitor_enable;
  } bpr_func_ctl_t;

  typedef struct packed {
    logic [3:0] balance_en;
    logic [1:0] monitor_mode;
    logic [1:0] cell_pick;
  } bpr_cell_ctl_t;

  typedef struct packed {
    logic discharge_fet_on;
    logic charge_fet_on;
    logic zero_volt_charge_fet;
    logic open_drain_enable;
    logic ship_mode;
    logic clock_monitor_disable;
    logic voltage_monitor_enable;
    logic pack_translate_enable;
    logic cell_out_ground;
    logic overload_sense_off;
    logic short_charge_sense_off;
    logic short_discharge_sense_off;
    logic thermistor_power_on;
    logic fault_latched;
    logic [1:0] cell_pick;
    logic [1:0] monitor_mode;
    logic [3:0] balance_en;
    logic [7:0] overload_threshold;
    logic [7:0] overload_delay;
    logic [7:0] short_charge_config;
    logic [7:0] short_discharge_config;
  } bpr_pins_t;

  typedef enum logic [2:0] {
    BPR_ST_IDLE,
    BPR_ST_ADDR,
    BPR_ST_REG,
    BPR_ST_WDATA,
    BPR_ST_ACK,
    BPR_ST_RDATA,
    BPR_ST_RACK
  } bpr_link_st_t;

  typedef struct packed {
    logic [BPR_SYNC_W-1:0] sync1;
    logic [BPR_SYNC_W-1:0] sync2;
    logic scl_d;
    logic sda_d;
    bpr_link_st_t st;
    bpr_link_st_t ack_next;
    logic [7:0] shift;
    logic [3:0] bit_cnt;
    logic master_ack;
    logic sda_drive;
    logic [7:0] ptr;
    logic [BPR_CTL_COUNT-1:0][7:0] ctl;
    logic [3:0] fault_prev;
    logic alert;
    logic fault_latched;
    logic release_prev;
    logic [1:0] strap_cnt;
    logic strap_done;
    bpr_pins_t pins;
  } bpr_state_t;

endpackage

/* File: tb/bpr_regs_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module bpr_regs_monitor
  import bpr_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Serial link
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  // Sense inputs and controls
  input wire bpr_sense_t sense_i,
  input wire logic system_alert_n_o,
  input wire bpr_pins_t pins_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  sequence fault_rise;
    $rose(sense_i.short_discharge) && !pins_o.short_discharge_sense_off;
  endsequence
  sequence sleep_held;
    sense_i.sleep_pin [*6];
  endsequence
  sda_low_a: assert property (sda_o == 1'b0) else $error("data pin driven high");
  sda_edge_a: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data pin moved while clock high");
  alert_set_a: assert property (fault_rise |-> ##[1:6] !system_alert_n_o)
    else $error("fault did not raise alert");
  alert_cause_a: assert property ($fell(system_alert_n_o) |->
    (|$past(sense_i[7:4], 2)) || (|$past(sense_i[7:4], 3)) || (|$past(sense_i[7:4], 4))
    || (|$past(sense_i[7:4], 5)) || (|$past(sense_i[7:4], 6))) else $error("alert without fault");
  latch_fet_a: assert property (pins_o.fault_latched |-> !pins_o.discharge_fet_on &&
    !pins_o.charge_fet_on && !pins_o.zero_volt_charge_fet) else $error("FET on while latched");
  reset_value_a: assert property ($fell(sys_rst_i) |-> ##1 pins_o.zero_volt_charge_fet &&
    pins_o.cell_out_ground && system_alert_n_o) else $error("wrong outputs after reset");
  sleep_off_a: assert property (sleep_held |-> !pins_o.discharge_fet_on &&
    !pins_o.thermistor_power_on && pins_o.overload_sense_off) else $error("output on in sleep");
  cell_gnd_a: assert property (pins_o.voltage_monitor_enable |-> !pins_o.cell_out_ground)
    else $error("cell output grounded while monitoring");
endmodule
bind bpr_regs bpr_regs_monitor bpr_regs_monitor_i (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
  .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .sense_i(sense_i),
  .system_alert_n_o(system_alert_n_o), .pins_o(pins_o));
`default_nettype wire

/* File: tb/bpr_host.sv */
`timescale 1ns/100ps
`default_nettype none
module bpr_host (
  // Pacing clock
  input wire logic clk_i,
  // Open-drain link, oe high pulls the data wire low
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_oe_o
);
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  // A quarter of the 160 ns link period; the link clock idles high between frames.
  task automatic q();
    repeat (4) @(negedge clk_i);
  endtask
  task automatic put(input logic b);
    sda_oe_o <= !b;
    q();
    scl_o <= 1'b1;
    q();
    q();
    scl_o <= 1'b0;
    q();
  endtask
  task automatic get(output logic b);
    sda_oe_o <= 1'b0;
    q();
    scl_o <= 1'b1;
    q();
    b = sda_i;
    q();
    scl_o <= 1'b0;
    q();
  endtask
  // The extra quarter lets the device let go of an acknowledge before a repeated start.
  task automatic start();
    sda_oe_o <= 1'b0;
    q();
    q();
    scl_o <= 1'b1;
    q();
    sda_oe_o <= 1'b1;
    q();
    scl_o <= 1'b0;
    q();
  endtask
  task automatic stop();
    sda_oe_o <= 1'b1;
    q();
    scl_o <= 1'b1;
    q();
    sda_oe_o <= 1'b0;
    q();
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) put(d[i]);
    get(b);
    ack = !b;
  endtask
  task automatic recv(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) get(d[i]);
    put(last);
  endtask
  task automatic write(input logic [7:0] dev, input logic [7:0] ra, input logic [7:0] d0,
    input logic [7:0] d1, input logic two, output logic ok);
    logic a0, a1, a2, a3;
    start();
    send(dev, a0);
    send(ra, a1);
    send(d0, a2);
    a3 = 1'b1;
    if (two) send(d1, a3);
    stop();
    ok = a0 & a1 & a2 & a3;
  endtask
  task automatic read(input logic [7:0] ra, output logic [7:0] d0, output logic [7:0] d1);
    logic a;
    start();
    send(8'h40, a);
    send(ra, a);
    start();
    send(8'h41, a);
    recv(1'b0, d0);
    recv(1'b1, d1);
    stop();
  endtask
endmodule
`default_nettype wire

/* File: tb/bpr_regs_bench.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin num_errors++; $display("mismatch %0t got %h want %h", $time, a, b); end end
module bpr_regs_bench
  import bpr_pkg::*;
;
  logic clock_i, sys_rst_i, scl, host_oe, dut_oe, sda_o, alert_n, ok;
  logic [7:0] d0, d1, v;
  bpr_sense_t sense;
  bpr_pins_t pins;
  int num_errors = 0;
  int checks_done = 0;
  logic [7:0] mask [8] = '{8'h1F, 8'h07, 8'h3F, 8'hFF, 8'h1F, 8'h0F, 8'hFF, 8'hFF};
  // Pulled-up data wire: low whenever either side pulls.
  wire logic sda = !(host_oe || dut_oe);
  bpr_regs bpr_regs_i (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(dut_oe), .sense_i(sense), .system_alert_n_o(alert_n),
    .pins_o(pins));
  bpr_host bpr_host_i (.clk_i(clock_i), .sda_i(sda), .scl_o(scl), .sda_oe_o(host_oe));
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = !clock_i;
  end
  task automatic conclude();
    if (num_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #900000;
    num_errors++;
    conclude();
  end
  task automatic rst(input logic strap);
    sys_rst_i = 1'b1;
    sense = '0;
    sense.precharge_mode_strap = strap;
    repeat (10) @(negedge clock_i);
    sys_rst_i = 1'b0;
    repeat (10) @(negedge clock_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bpr_host_i.write(8'h40, a, d, 8'h00, 1'b0, ok);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    bpr_host_i.read(a, d0, d1);
    `CHK(d0, e);
    `CHK(d1, e);
  endtask
  task automatic settle();
    repeat (8) @(negedge clock_i);
  endtask
  initial begin
    rst(1'b0);
    `CHK({pins.zero_volt_charge_fet, pins.cell_out_ground, pins.charge_fet_on}, 3'h6);
    for (int a = 0; a < 10; a++) rd(a[7:0], 8'h00);
    wr(8'h00, 8'hFF);
    rd(8'h00, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr(8'(i + 1), 8'hFE);
      rd(8'(i + 1), 8'hFE & mask[i]);
    end
    `CHK({pins.discharge_fet_on, pins.charge_fet_on, pins.zero_volt_charge_fet}, 3'h6);
    `CHK({pins.open_drain_enable, pins.thermistor_power_on}, 2'h3);
    `CHK({pins.overload_sense_off, pins.short_charge_sense_off}, 2'h3);
    `CHK({pins.short_discharge_sense_off, pins.clock_monitor_disable}, 2'h3);
    `CHK({pins.overload_threshold, pins.overload_delay}, 16'h1E0E);
    `CHK({pins.short_charge_config, pins.short_discharge_config}, 16'hFEFE);
    for (int k = 0; k < 4; k++) begin
      v = {4'(1 << k), 2'(k), 2'(k)};
      wr(8'h04, v);
      `CHK({pins.balance_en, pins.monitor_mode, pins.cell_pick}, v);
    end
    wr(8'h03, 8'h03);
    `CHK({pins.voltage_monitor_enable, pins.pack_translate_enable}, 2'h3);
    `CHK(pins.cell_out_ground, 1'b0);
    sense.pack_absent = 1'b1;
    settle();
    `CHK(pins.ship_mode, 1'b1);
    sense.pack_absent = 1'b0;
    wr(8'h02, 8'h00);
    for (int i = 0; i < 4; i++) begin
      sense[7 - i] = 1'b1;
      settle();
      `CHK(alert_n, 1'b0);
      `CHK(pins.fault_latched & !pins.discharge_fet_on, 1'b1);
      rd(8'h00, 8'(1 << i));
      `CHK(alert_n, 1'b1);
      sense[7 - i] = 1'b0;
      wr(8'h01, 8'h1F);
      `CHK(pins.fault_latched, 1'b1);
      wr(8'h01, 8'h1E);
      `CHK(pins.fault_latched | !pins.discharge_fet_on, 1'b0);
    end
    sense.zero_volt_clamp = 1'b1;
    rd(8'h00, 8'h20);
    sense.zero_volt_clamp = 1'b0;
    wr(8'h01, 8'h00);
    wr(8'h02, 8'h04);
    wr(8'h03, 8'h1C);
    sense[7:4] = 4'hF;
    settle();
    `CHK(alert_n, 1'b1);
    rd(8'h00, 8'h00);
    sense[7:4] = 4'h0;
    wr(8'h02, 8'h01);
    rd(8'h00, 8'hFF);
    wr(8'h04, 8'h5A);
    wr(8'h02, 8'h00);
    rd(8'h04, 8'h5A);
    sense.sleep_pin = 1'b1;
    rd(8'h01, 8'hFF);
    sense.sleep_pin = 1'b0;
    bpr_host_i.write(8'h40, 8'h05, 8'h03, 8'h11, 1'b1, ok);
    `CHK(ok, 1'b1);
    rd(8'h05, 8'h11);
    rd(8'h06, 8'h0E);
    bpr_host_i.write(8'h42, 8'h05, 8'h07, 8'h00, 1'b0, ok);
    `CHK(ok, 1'b0);
    rd(8'h05, 8'h11);
    rst(1'b1);
    `CHK(pins.charge_fet_on, 1'b1);
    rd(8'h01, 8'h04);
    conclude();
  end
endmodule
`default_nettype wire
